// ---- hdl/ahs_defines.vh ----
// Register map, field positions, reset values and method codes of the axis homing sequencer.
`ifndef AHS_DEFINES_VH
`define AHS_DEFINES_VH

// Byte offsets of the register words.
`define AHS_OFS_CTRL 5'h00
`define AHS_OFS_METHOD 5'h04
`define AHS_OFS_ASSIGN 5'h08
`define AHS_OFS_STATUS 5'h0c
`define AHS_OFS_HOMEPOS 5'h10
`define AHS_OFS_COORD 5'h14

// Control word bits, write-one actions.
`define AHS_CTRL_START 0
`define AHS_CTRL_ABORT 1

// Input assignment word bits.
`define AHS_ASN_REF 0
`define AHS_ASN_NEG 1
`define AHS_ASN_POS 2

// Status word bits.
`define AHS_ST_BUSY 0
`define AHS_ST_DONE 1
`define AHS_ST_ERR 2
`define AHS_ST_MOVING 3
`define AHS_ST_DIR 4
`define AHS_ST_ECODE_LO 8

// Error codes.
`define AHS_ERR_NONE 2'h0
`define AHS_ERR_METHOD 2'h1
`define AHS_ERR_INPUT 2'h2

// Reset values.
`define AHS_RST_METHOD 6'h00
`define AHS_RST_ASSIGN 3'h0

// Homing method codes.
`define AHS_M_LIMIDX_NEG 6'h01
`define AHS_M_LIMIDX_POS 6'h02
`define AHS_M_REFIDX_P 6'h08
`define AHS_M_REFREAR_P 6'h0a
`define AHS_M_REFIDX_N 6'h0c
`define AHS_M_REFREAR_N 6'h0e
`define AHS_M_LIM_NEG 6'h11
`define AHS_M_LIM_POS 6'h12
`define AHS_M_REF_P 6'h18
`define AHS_M_REF_N 6'h1c
`define AHS_M_IDX_N 6'h21
`define AHS_M_IDX_P 6'h22
`define AHS_M_DATASET 6'h25

`endif

// ---- hdl/ahs_homing_sequencer.v ----
// Homing sequencer for one servo axis with its Avalon-MM register slave.
`timescale 1ns/100ps
`include "ahs_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module ahs_homing_sequencer (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Avalon-MM slave
   input wire [4:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output reg [31:0] avs_readdata,
   output wire avs_waitrequest,
   // Switch and encoder pins
   input wire nearReferenceSwitch,
   input wire negativeLimitInput,
   input wire positiveLimitInput,
   input wire indexPulse,
   // Encoder position from the same-clock counter
   input wire [31:0] encoderPos,
   // Motion command to the drive
   output reg motionEnable_r,
   output reg motionDir_r,
   // Status and coordinate
   output reg homeBusy_r,
   output reg homeDone_r,
   output reg homeError_r,
   output reg [31:0] posCoord_r
);

   localparam S_IDLE = 3'h0;
   localparam S_LEAVE = 3'h1;
   localparam S_SEEK = 3'h2;
   localparam S_CLEAR = 3'h3;
   localparam S_INDEX = 3'h4;
   localparam S_STOP = 3'h5;

   localparam K_REFIDX = 3'h0;
   localparam K_REFREAR = 3'h1;
   localparam K_REF = 3'h2;
   localparam K_LIMIDX = 3'h3;
   localparam K_LIM = 3'h4;
   localparam K_IDX = 3'h5;
   localparam K_SET = 3'h6;

   // Trigger select: which input the seek and clear phases watch.
   localparam T_REF = 2'h0;
   localparam T_NEG = 2'h1;
   localparam T_POS = 2'h2;

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers with agreement filter.

   wire [3:0] pinIn;
   wire [3:0] pinRise;
   wire [3:0] pinFall;
   wire [3:0] pinLvl;

   assign pinIn = {indexPulse, positiveLimitInput, negativeLimitInput, nearReferenceSwitch};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         reg s1_r;
         reg s2_r;
         reg s3_r;
         reg lvl_r;
         always @(posedge clk_sys) begin
            if (rst) begin
               s1_r <= 1'b0;
               s2_r <= 1'b0;
               s3_r <= 1'b0;
               lvl_r <= 1'b0;
            end else begin
               s1_r <= pinIn[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  lvl_r <= s3_r;
               end
            end
         end
         assign pinLvl[gi] = lvl_r;
         // A level high is active for every pin, limits included.
         assign pinRise[gi] = (s2_r == s3_r) & s3_r & ~lvl_r;
         assign pinFall[gi] = (s2_r == s3_r) & ~s3_r & lvl_r;
      end
   endgenerate

   wire refFall = pinFall[0];
   wire idxRise = pinRise[3];

   ////////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait state on every access.

   reg ack_r;
   reg [5:0] method_r;
   reg [2:0] assign_r;
   reg [31:0] homePos_r;
   reg [1:0] errCode_r;
   reg [2:0] state_r;

   wire acc = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ack_r;
   wire wrTake = avs_write & ack_r;
   wire wrCtrl = wrTake & (avs_address == `AHS_OFS_CTRL) & avs_byteenable[0];
   wire wrStat = wrTake & (avs_address == `AHS_OFS_STATUS) & avs_byteenable[0];
   wire startReq = wrCtrl & avs_writedata[`AHS_CTRL_START];
   wire abortReq = wrCtrl & avs_writedata[`AHS_CTRL_ABORT];

   reg [31:0] rdMux;
   always @* begin
      rdMux = 32'h0;
      case (avs_address)
         `AHS_OFS_METHOD: rdMux = {26'h0, method_r};
         `AHS_OFS_ASSIGN: rdMux = {29'h0, assign_r};
         `AHS_OFS_STATUS: begin
            rdMux[`AHS_ST_BUSY] = homeBusy_r;
            rdMux[`AHS_ST_DONE] = homeDone_r;
            rdMux[`AHS_ST_ERR] = homeError_r;
            rdMux[`AHS_ST_MOVING] = motionEnable_r;
            rdMux[`AHS_ST_DIR] = motionDir_r;
            rdMux[`AHS_ST_ECODE_LO + 1:`AHS_ST_ECODE_LO] = errCode_r;
         end
         `AHS_OFS_HOMEPOS: rdMux = homePos_r;
         `AHS_OFS_COORD: rdMux = posCoord_r;
         default: rdMux = 32'h0;
      endcase
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         ack_r <= 1'b0;
         avs_readdata <= 32'h0;
         method_r <= `AHS_RST_METHOD;
         assign_r <= `AHS_RST_ASSIGN;
      end else begin
         ack_r <= acc & ~ack_r;
         if (avs_read & ~ack_r) begin
            avs_readdata <= rdMux;
         end
         // Configuration is frozen while a sequence runs so the decode cannot shift mid-move.
         if (wrTake & ~homeBusy_r & avs_byteenable[0]) begin
            if (avs_address == `AHS_OFS_METHOD) begin
               method_r <= avs_writedata[5:0];
            end
            if (avs_address == `AHS_OFS_ASSIGN) begin
               assign_r <= avs_writedata[2:0];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Method decode.

   reg mValid;
   reg [2:0] mKind;
   reg mHomePos;
   reg mInputsOk;
   always @* begin
      mValid = 1'b1;
      mKind = K_SET;
      mHomePos = 1'b1;
      mInputsOk = 1'b1;
      case (method_r)
         `AHS_M_REFIDX_P: begin mKind = K_REFIDX; mHomePos = 1'b1; end
         `AHS_M_REFIDX_N: begin mKind = K_REFIDX; mHomePos = 1'b0; end
         `AHS_M_REFREAR_P: begin mKind = K_REFREAR; mHomePos = 1'b1; end
         `AHS_M_REFREAR_N: begin mKind = K_REFREAR; mHomePos = 1'b0; end
         `AHS_M_REF_P: begin mKind = K_REF; mHomePos = 1'b1; end
         `AHS_M_REF_N: begin mKind = K_REF; mHomePos = 1'b0; end
         `AHS_M_LIMIDX_POS: begin
            mKind = K_LIMIDX;
            mHomePos = 1'b0;
            mInputsOk = assign_r[`AHS_ASN_POS];
         end
         `AHS_M_LIMIDX_NEG: begin
            mKind = K_LIMIDX;
            mHomePos = 1'b1;
            mInputsOk = assign_r[`AHS_ASN_NEG];
         end
         `AHS_M_LIM_NEG: begin
            mKind = K_LIM;
            mHomePos = 1'b0;
            mInputsOk = assign_r[`AHS_ASN_NEG];
         end
         `AHS_M_LIM_POS: begin
            mKind = K_LIM;
            mHomePos = 1'b1;
            mInputsOk = assign_r[`AHS_ASN_POS];
         end
         `AHS_M_IDX_N: begin mKind = K_IDX; mHomePos = 1'b0; end
         `AHS_M_IDX_P: begin mKind = K_IDX; mHomePos = 1'b1; end
         `AHS_M_DATASET: mKind = K_SET;
         default: mValid = 1'b0;
      endcase
      if (mKind == K_REFIDX || mKind == K_REFREAR || mKind == K_REF) begin
         mInputsOk = assign_r[`AHS_ASN_REF] & assign_r[`AHS_ASN_NEG];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sequencer.

   reg [2:0] kind_r;
   reg homeDir_r;
   reg [1:0] trig_r;

   // For the limit methods the watched limit is the one on the side the axis first moves to.
   wire limitSel = mHomePos ^ (mKind == K_LIMIDX);
   wire [1:0] mTrig = (mKind == K_REFIDX || mKind == K_REFREAR || mKind == K_REF) ? T_REF :
                      (limitSel ? T_POS : T_NEG);
   wire trigRise = pinRise[trig_r];
   wire trigFall = pinFall[trig_r];
   wire mTrigLvl = pinLvl[mTrig];
   wire refKind = (mKind == K_REFIDX || mKind == K_REFREAR || mKind == K_REF);

   always @(posedge clk_sys) begin
      if (rst) begin
         state_r <= S_IDLE;
         kind_r <= K_SET;
         homeDir_r <= 1'b1;
         trig_r <= T_REF;
         motionEnable_r <= 1'b0;
         motionDir_r <= 1'b1;
         homeBusy_r <= 1'b0;
         homeDone_r <= 1'b0;
         homeError_r <= 1'b0;
         errCode_r <= `AHS_ERR_NONE;
         homePos_r <= 32'h0;
         posCoord_r <= 32'h0;
      end else begin
         posCoord_r <= encoderPos - homePos_r;
         // Software clears sticky flags by writing one; a same-cycle set below overrides it.
         if (wrStat & avs_writedata[`AHS_ST_DONE]) begin
            homeDone_r <= 1'b0;
         end
         if (wrStat & avs_writedata[`AHS_ST_ERR]) begin
            homeError_r <= 1'b0;
         end
         case (state_r)
            S_IDLE: begin
               if (startReq) begin
                  kind_r <= mKind;
                  homeDir_r <= mHomePos;
                  trig_r <= mTrig;
                  if (!mValid || !mInputsOk) begin
                     homeError_r <= 1'b1;
                     errCode_r <= mValid ? `AHS_ERR_INPUT : `AHS_ERR_METHOD;
                  end else begin
                     homeBusy_r <= 1'b1;
                     homeDone_r <= 1'b0;
                     errCode_r <= `AHS_ERR_NONE;
                     if (mKind == K_SET) begin
                        state_r <= S_STOP;
                     end else if (mKind == K_IDX) begin
                        motionEnable_r <= 1'b1;
                        motionDir_r <= mHomePos;
                        state_r <= S_INDEX;
                     end else if (refKind && mTrigLvl) begin
                        // Start inside the reference: back out of it first.
                        motionEnable_r <= 1'b1;
                        motionDir_r <= ~mHomePos;
                        state_r <= S_LEAVE;
                     end else if (mKind == K_LIMIDX && mTrigLvl) begin
                        motionEnable_r <= 1'b1;
                        motionDir_r <= mHomePos;
                        state_r <= S_CLEAR;
                     end else begin
                        // Index edges seen here are not yet watched.
                        motionEnable_r <= 1'b1;
                        motionDir_r <= (mKind == K_LIMIDX) ? ~mHomePos : mHomePos;
                        state_r <= S_SEEK;
                     end
                  end
               end
            end
            S_LEAVE: begin
               if (refFall) begin
                  motionDir_r <= homeDir_r;
                  state_r <= S_SEEK;
               end
            end
            S_SEEK: begin
               if (trigRise) begin
                  if (kind_r == K_REF || kind_r == K_LIM) begin
                     motionEnable_r <= 1'b0;
                     state_r <= S_STOP;
                  end else if (kind_r == K_REFIDX) begin
                     state_r <= S_INDEX;
                  end else if (kind_r == K_REFREAR) begin
                     state_r <= S_CLEAR;
                  end else begin
                     motionDir_r <= homeDir_r;
                     state_r <= S_CLEAR;
                  end
               end
            end
            S_CLEAR: begin
               // For K_REFREAR and K_LIMIDX, index search opens only once the switch or limit has gone inactive.
               if (trigFall) begin
                  state_r <= S_INDEX;
               end
            end
            S_INDEX: begin
               if (idxRise) begin
                  motionEnable_r <= 1'b0;
                  state_r <= S_STOP;
               end
            end
            S_STOP: begin
               motionEnable_r <= 1'b0;
               homePos_r <= encoderPos;
               homeBusy_r <= 1'b0;
               homeDone_r <= 1'b1;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
         if (abortReq && state_r != S_IDLE) begin
            motionEnable_r <= 1'b0;
            homeBusy_r <= 1'b0;
            state_r <= S_IDLE;
         end
      end
   end

endmodule

// ---- test/ahs_drive_model.sv ----
// Behavioural servo drive: position counter with switch and index pins.
`timescale 1ns/100ps
module ahs_drive_model (
   // Clock, reset and motion command
   input logic clk_sys,
   input logic rst,
   input logic motionEnable_r,
   input logic motionDir_r,
   // Bench control: slow motion and position preset
   input logic slow,
   input logic load,
   input logic [31:0] loadPos,
   // Pins and position
   output logic nearReferenceSwitch,
   output logic negativeLimitInput,
   output logic positiveLimitInput,
   output logic indexPulse,
   output logic [31:0] encoderPos
);
   logic signed [31:0] pos_r;
   logic [1:0] div_r;
   ////////////////////////////////////////////////////////////
   // Slow mode steps every fourth cycle, so pin pulses last longer.
   always @(posedge clk_sys) begin
      div_r <= rst ? 2'h0 : div_r + 2'h1;
      if (rst || load) begin
         pos_r <= rst ? 32'sh0 : loadPos;
      end else if (motionEnable_r && (!slow || div_r == 2'h0)) begin
         pos_r <= motionDir_r ? pos_r + 1 : pos_r - 1;
      end
   end
   assign nearReferenceSwitch = pos_r >= 100 && pos_r <= 139;
   assign negativeLimitInput = pos_r < -200;
   assign positiveLimitInput = pos_r > 300;
   // The index is two counts wide so that a fast pass still spans two clocks.
   assign indexPulse = pos_r[3:1] == 3'h0;
   assign encoderPos = pos_r;
endmodule

// ---- test/ahs_homing_chk.sv ----
// Concurrent checks on the homing sequencer ports.
`timescale 1ns/100ps
`include "ahs_defines.vh"
module ahs_homing_chk (
   // Clock, reset and register bus
   input logic clk_sys,
   input logic rst,
   input logic [4:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0] avs_byteenable,
   input logic avs_waitrequest,
   // Pins and outputs
   input logic nearReferenceSwitch,
   input logic positiveLimitInput,
   input logic motionEnable_r,
   input logic motionDir_r,
   input logic homeBusy_r,
   input logic homeDone_r,
   input logic homeError_r,
   input logic [31:0] posCoord_r
);
   logic wrAcc;
   logic [5:0] method_r;
   ////////////////////////////////////////////////////////////
   // The method is internal to the design, so it is tracked from bus writes.
   assign wrAcc = avs_write && !avs_waitrequest && avs_byteenable[0] && !homeBusy_r;
   always @(posedge clk_sys) begin
      if (rst) begin
         method_r <= `AHS_RST_METHOD;
      end else if (wrAcc && avs_address == `AHS_OFS_METHOD) begin
         method_r <= avs_writedata[5:0];
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("Access waited more than one cycle.");
   a_move_busy: assert property (motionEnable_r |-> homeBusy_r)
      else $error("Motion outside a sequence.");
   a_done_idle: assert property ($rose(homeDone_r) |-> !homeBusy_r && !motionEnable_r)
      else $error("Done while still moving.");
   a_coord_zero: assert property ($rose(homeDone_r) |-> ##[1:2] posCoord_r == 32'h0)
      else $error("Coordinate not zero at home.");
   a_err_nomove: assert property ($rose(homeError_r) |-> !motionEnable_r && !homeBusy_r)
      else $error("Refused start still moved.");
   a_ref_stop: assert property (method_r == `AHS_M_REF_P && motionEnable_r && motionDir_r
      && $rose(nearReferenceSwitch) |-> ##[1:7] !motionEnable_r) else $error("No stop at switch.");
   a_lim_stop: assert property (method_r == `AHS_M_LIM_POS && motionEnable_r
      && $rose(positiveLimitInput) |-> ##[1:7] !motionEnable_r) else $error("No stop at limit.");
   a_lim_rev: assert property (method_r == `AHS_M_LIMIDX_POS && motionEnable_r && motionDir_r
      && $rose(positiveLimitInput) |-> ##[1:7] !motionDir_r) else $error("No reversal at limit.");
   a_set_done: assert property (wrAcc && avs_address == `AHS_OFS_CTRL && avs_writedata[0]
      && method_r == `AHS_M_DATASET |=> !motionEnable_r ##[1:3] homeDone_r) else $error("Data set failed.");
endmodule
bind ahs_homing_sequencer ahs_homing_chk u_chk (.clk_sys, .rst, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_waitrequest, .nearReferenceSwitch, .positiveLimitInput,
   .motionEnable_r, .motionDir_r, .homeBusy_r, .homeDone_r, .homeError_r, .posCoord_r);

// ---- test/testbench.sv ----
// Self-checking bench for the axis homing sequencer.
`timescale 1ns/100ps
`include "ahs_defines.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
$display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, rdN, rd, posCoord_r, encoderPos;
   logic [31:0] loadPos = 32'h0;
   logic avs_waitrequest, waitN, nearReferenceSwitch, negativeLimitInput, positiveLimitInput, indexPulse;
   logic motionEnable_r, motionDir_r, homeBusy_r, homeDone_r, homeError_r;
   logic slow = 1'b0;
   logic load = 1'b0;
   int error_cnt = 0;
   int total_checks = 0;
   int cycles = 0;
   logic [4:0] regOfs [4] = '{`AHS_OFS_METHOD, `AHS_OFS_ASSIGN, `AHS_OFS_STATUS, 5'h18};
   logic [31:0] regRst [4] = '{32'h0, 32'h0, 32'h10, 32'h0};
   logic [5:0] errM [5] = '{`AHS_M_REF_P, `AHS_M_REFIDX_N, `AHS_M_LIMIDX_POS, `AHS_M_LIMIDX_NEG, 6'h03};
   logic [2:0] errA [5] = '{3'h5, 3'h6, 3'h3, 3'h5, 3'h7};
   logic [5:0] dirM [6] = '{`AHS_M_REFIDX_P, `AHS_M_REFREAR_P, `AHS_M_REF_P, `AHS_M_REFIDX_N,
      `AHS_M_REFREAR_N, `AHS_M_REF_N};
   logic [5:0] runM [13] = '{`AHS_M_REFIDX_P, `AHS_M_REFREAR_P, `AHS_M_REF_P, `AHS_M_LIMIDX_NEG,
      `AHS_M_LIMIDX_POS, `AHS_M_LIM_NEG, `AHS_M_LIM_POS, `AHS_M_IDX_N, `AHS_M_IDX_P, `AHS_M_REFIDX_N,
      `AHS_M_REFREAR_N, `AHS_M_REF_N, `AHS_M_DATASET};
   logic [31:0] runP [13] = '{0, 0, 0, 0, 0, 0, 0, 8, 8, 200, 200, 200, 0};
   always #5 clk_sys = ~clk_sys;
   ahs_homing_sequencer u_dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .nearReferenceSwitch, .negativeLimitInput,
      .positiveLimitInput, .indexPulse, .encoderPos, .motionEnable_r, .motionDir_r, .homeBusy_r,
      .homeDone_r, .homeError_r, .posCoord_r);
   ahs_drive_model u_drive (.clk_sys, .rst, .motionEnable_r, .motionDir_r, .slow, .load, .loadPos,
      .nearReferenceSwitch, .negativeLimitInput, .positiveLimitInput, .indexPulse, .encoderPos);
   ////////////////////////////////////////////////////////////
   // Sampled on the falling edge so the rising-edge test never races the design.
   always @(negedge clk_sys) begin
      waitN <= avs_waitrequest;
      rdN <= avs_readdata;
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= d;
      do @(posedge clk_sys); while (waitN !== 1'b0);
      rd = rdN;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic home(input logic [5:0] m, input logic [31:0] p);
      @(posedge clk_sys);
      load <= 1'b1;
      loadPos <= p;
      slow <= 1'($urandom);
      @(posedge clk_sys);
      load <= 1'b0;
      repeat (6) @(posedge clk_sys);
      bus(1, `AHS_OFS_METHOD, {26'h0, m});
      bus(1, `AHS_OFS_CTRL, 32'h1);
   endtask
   task automatic waitEnd();
      @(negedge clk_sys);
      for (int i = 0; i < 8000 && !(homeDone_r || homeError_r); i++) @(negedge clk_sys);
      `CHK(homeDone_r || homeError_r, 1'b1)
   endtask
   // Final travel direction and the switch, limit or index position where the home edge lies.
   function automatic logic [32:0] expHome(input logic [5:0] m, input logic [31:0] p);
      case (m)
         `AHS_M_REFIDX_P: expHome = {1'b1, 32'd112};
         `AHS_M_REFREAR_P: expHome = {1'b1, 32'd144};
         `AHS_M_REF_P: expHome = {1'b1, 32'd100};
         `AHS_M_LIMIDX_NEG: expHome = {1'b1, -32'sd192};
         `AHS_M_LIM_POS: expHome = {1'b1, 32'd301};
         `AHS_M_IDX_P: expHome = {1'b1, 32'd16};
         `AHS_M_REFIDX_N: expHome = {1'b0, 32'd129};
         `AHS_M_REFREAR_N: expHome = {1'b0, 32'd97};
         `AHS_M_REF_N: expHome = {1'b0, 32'd139};
         `AHS_M_LIMIDX_POS: expHome = {1'b0, 32'd289};
         `AHS_M_LIM_NEG: expHome = {1'b0, -32'sd201};
         `AHS_M_IDX_N: expHome = {1'b0, 32'd1};
         default: expHome = {1'b1, p};
      endcase
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      logic [32:0] e;
      logic [31:0] p, off, lim;
      void'($urandom(27748));
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      bus(1, 5'h18, 32'hffffffff);
      foreach (regOfs[i]) begin
         bus(0, regOfs[i], 0);
         `CHK(rd, regRst[i])
      end
      for (int i = 0; i < 5; i++) begin
         bus(1, `AHS_OFS_ASSIGN, {29'h0, errA[i]});
         home(errM[i], 32'h0);
         waitEnd();
         bus(0, `AHS_OFS_STATUS, 0);
         e = {29'h0, ((i == 4) ? `AHS_ERR_METHOD : `AHS_ERR_INPUT), 2'b10};
         `CHK({rd[9:8], rd[2], motionEnable_r}, e[3:0])
         bus(1, `AHS_OFS_STATUS, 32'h4);
         @(negedge clk_sys);
         `CHK(homeError_r, 1'b0)
      end
      // Switch active at start: the first move must run against the home direction.
      foreach (dirM[i]) begin
         home(dirM[i], 32'd120);
         repeat (3) @(negedge clk_sys);
         `CHK({motionEnable_r, motionDir_r}, {1'b1, i > 2})
         bus(1, `AHS_OFS_CTRL, 32'h2);
      end
      foreach (runM[i]) begin
         p = (runM[i] == `AHS_M_DATASET) ? 32'd400 + ($urandom % 256) : runP[i];
         home(runM[i], p);
         waitEnd();
         e = expHome(runM[i], p);
         bus(0, `AHS_OFS_HOMEPOS, 0);
         off = e[32] ? rd - e[31:0] : e[31:0] - rd;
         lim = (runM[i] == `AHS_M_DATASET) ? 32'h0 : 32'hc;
         `CHK(off <= lim, 1'b1)
         bus(0, `AHS_OFS_COORD, 0);
         `CHK(rd, 32'h0)
         bus(0, `AHS_OFS_STATUS, 0);
         `CHK({rd[3:0], motionEnable_r}, 5'b00100)
      end
      end_of_test();
   end
endmodule
